// file: dv/sie_engine_model.sv
/*
 engine and line model facing the block.
 assumes callers enter its tasks just after a rising edge.
*/
`default_nettype none

module sie_engine_model (
   input wire logic clk_in,
   output logic xact_done_out,
   output sie_ctl_pkg::xact_status_s status_out,
   output sie_ctl_pkg::line_status_s line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] sent[$];
   initial begin
      xact_done_out = 1'b0;
      status_out = '0;
      line_out = '0;
   end
   task automatic burst(input int n);
      logic [5:0] s;
      for (int i = 0; i < n; i++) begin
         s = 6'($urandom);
         sent.push_back(s);
         status_out <= s;
         xact_done_out <= 1'b1;
         @(posedge clk_in);
      end
      xact_done_out <= 1'b0;
      status_out <= ~s;
   endtask
   task automatic pulse(input int b);
      line_out[b] <= 1'b1;
      @(posedge clk_in);
      line_out[b] <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask
   task automatic levels(input logic [1:0] r);
      line_out[5:4] <= r;
      @(posedge clk_in);
   endtask
endmodule // sie_engine_model
`default_nettype wire

// file: dv/sie_status_control_monitor.sv
/*
 port checker for the status, control and address block.
 assumes the block's top ports only, one clock, sync reset.
*/
`default_nettype none

module sie_status_control_monitor #(
   parameter int depth = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [11:0] paddr_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic xact_done_in,
   input wire sie_ctl_pkg::line_status_s line_in,
   input wire sie_ctl_pkg::engine_ctl_s engine_out,
   input wire logic token_done_flag_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_rdy; psel_in && !penable_in |=> pready_out; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_err; psel_in && !penable_in && paddr_in > 12'h00c |=> pslverr_out; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_push;
      xact_done_in && engine_out.module_enable ##1 engine_out.module_enable |=> token_done_flag_out;
   endproperty
   a_push: assert property (p_push) else $error("flag not raised");
   property p_busy; engine_out.host_mode && line_in.token_started |-> ##[1:2] engine_out.suspend_or_busy_bit; endproperty
   a_busy: assert property (p_busy) else $error("busy not set");
   property p_setup;
      !engine_out.host_mode && engine_out.module_enable && line_in.setup_token_seen
         |-> ##[1:2] engine_out.suspend_or_busy_bit;
   endproperty
   a_setup: assert property (p_setup) else $error("suspend not set");
   property p_brst; engine_out.drive_bus_reset |-> engine_out.host_mode || $past(engine_out.host_mode); endproperty
   a_brst: assert property (p_brst) else $error("bus reset outside host");
   property p_eop; $fell(engine_out.drive_resume) && engine_out.host_mode |-> ##[0:1] engine_out.ls_eop_pulse; endproperty
   a_eop: assert property (p_eop) else $error("no eop after resume");
   // the bank pulse leaves one cycle before the registered enable shows
   property p_en; $rose(engine_out.module_enable) |-> $past(engine_out.force_even_banks); endproperty
   a_en: assert property (p_en) else $error("banks not forced even");
   property p_sof; !engine_out.module_enable && !$past(engine_out.module_enable) |-> !engine_out.sof_enable; endproperty
   a_sof: assert property (p_sof) else $error("frame tokens while off");
   property p_adr; line_in.bus_reset_decoded |-> ##[1:2] engine_out.device_address == 7'h00; endproperty
   a_adr: assert property (p_adr) else $error("address not cleared");
   c_push: cover property (xact_done_in && token_done_flag_out);
   c_eop: cover property (engine_out.ls_eop_pulse);
   c_brst: cover property (engine_out.drive_bus_reset);
endmodule // sie_status_control_monitor

bind sie_status_control sie_status_control_monitor #(.depth(depth)) mon_i (.clk_in(clk_in),
   .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .xact_done_in(xact_done_in),
   .line_in(line_in), .engine_out(engine_out), .token_done_flag_out(token_done_flag_out));
`default_nettype wire

// file: dv/usb_sie_status_control_addr_tb.sv
/*
 self-checking bench for the status, control and address block.
 assumes the engine model beside it and apb zero wait states.
*/
`default_nettype none

module usb_sie_status_control_addr_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0;
   logic [3:0] pstrb_in = 4'hf;
   logic [31:0] prdata_out, rd;
   logic pready_out, pslverr_out, xact_done_in, token_done_flag_out, queue_overflow_out, err;
   sie_ctl_pkg::xact_status_s xact_status_in;
   sie_ctl_pkg::line_status_s line_in;
   sie_ctl_pkg::engine_ctl_s engine_out;
   logic [5:0] exp_q[$];
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int ovf = 0;
   int evens = 0;
   int eops = 0;
   int e;
   always #4 clk_in = ~clk_in;
   sie_status_control #(.depth(4)) sie_status_control_i (.clk_in(clk_in), .rst_in(rst_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out), .xact_done_in(xact_done_in), .xact_status_in(xact_status_in),
      .line_in(line_in), .engine_out(engine_out), .token_done_flag_out(token_done_flag_out),
      .queue_overflow_out(queue_overflow_out));
   sie_engine_model sie_engine_model_i (.clk_in(clk_in), .xact_done_out(xact_done_in),
      .status_out(xact_status_in), .line_out(line_in));
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      ovf <= ovf + int'(queue_overflow_out);
      evens <= evens + int'(engine_out.force_even_banks);
      eops <= eops + int'(engine_out.ls_eop_pulse);
      if (cycles == 4000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= {24'h0, d};
      @(posedge clk_in);
      penable_in <= 1'b1;
      do @(posedge clk_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 8'h00);
      chk(n, x, rd);
   endtask
   initial begin
      void'($urandom(32'h56b3));
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      rdchk("ctl_rst", 12'h004, 32'h0);
      rdchk("addr_rst", 12'h008, 32'h0);
      rdchk("stat_empty", 12'h000, 32'h0);
      apb(1'b0, 12'h010, 8'h00);
      chk("unmapped", 32'h1, {31'h0, err});
      apb(1'b1, 12'h004, 8'h01);
      apb(1'b1, 12'h008, 8'ha5);
      rdchk("addr", 12'h008, 32'ha5);
      pstrb_in <= 4'he;
      apb(1'b1, 12'h008, 8'h11);
      pstrb_in <= 4'hf;
      rdchk("addr_strb", 12'h008, 32'ha5);
      chk("dev_addr", 32'ha5, {engine_out.low_speed_select, engine_out.device_address});
      sie_engine_model_i.pulse(0);
      rdchk("addr_bus_rst", 12'h008, 32'h0);
      $display("test registers done");
      sie_engine_model_i.burst(6);
      foreach (sie_engine_model_i.sent[k])
         if (exp_q.size() < 4) exp_q.push_back(sie_engine_model_i.sent[k]);
      for (int i = 0; i < 5; i++) begin
         rdchk("stat", 12'h000, exp_q.size() ? {exp_q[0], 2'b00} : 32'h0);
         chk("tok_done", exp_q.size() != 0, token_done_flag_out);
         if (exp_q.size()) void'(exp_q.pop_front());
         apb(1'b1, 12'h00c, 8'h01);
      end
      chk("overflow", sie_engine_model_i.sent.size() - 4, ovf);
      $display("test queue done");
      for (int i = 0; i < 5; i++) begin
         sie_engine_model_i.levels(2'($urandom));
         rdchk("live", 12'h004, {24'h0, line_in.live_j_state, line_in.se0, 6'h01});
      end
      sie_engine_model_i.levels(2'b00);
      apb(1'b1, 12'h004, 8'h19);
      chk("host_rst", 32'h3, {engine_out.host_mode, engine_out.drive_bus_reset});
      apb(1'b1, 12'h008, 8'h85);
      chk("host_addr", 32'h85, {engine_out.low_speed_select, engine_out.device_address});
      sie_engine_model_i.pulse(2);
      rdchk("busy", 12'h004, 32'h39);
      sie_engine_model_i.pulse(1);
      rdchk("idle", 12'h004, 32'h19);
      apb(1'b1, 12'h004, 8'h0d);
      chk("resume", 32'h2, {engine_out.drive_resume, engine_out.drive_bus_reset});
      apb(1'b1, 12'h004, 8'h09);
      chk("sof_on", 32'h1, {engine_out.drive_resume, engine_out.sof_enable});
      apb(1'b1, 12'h004, 8'h08);
      chk("sof_off", 32'h0, {engine_out.module_enable, engine_out.sof_enable});
      chk("ls_eop", 32'h1, eops);
      $display("test host done");
      apb(1'b1, 12'h004, 8'h01);
      sie_engine_model_i.pulse(3);
      rdchk("suspend", 12'h004, 32'h21);
      apb(1'b1, 12'h004, 8'h01);
      rdchk("resumed", 12'h004, 32'h01);
      e = evens;
      apb(1'b1, 12'h004, 8'h03);
      chk("even_banks", e + 1, evens);
      rdchk("odd_rst_rd", 12'h004, 32'h01);
      $display("test target done");
      apb(1'b1, 12'h008, 8'h5a);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      rdchk("addr_sys_rst", 12'h008, 32'h0);
      rdchk("ctl_sys_rst", 12'h004, 32'h0);
      $display("test reset done");
      finish_test();
   end
endmodule // usb_sie_status_control_addr_tb
`default_nettype wire

// file: hw/sie_ctl_pkg.sv
/*
 package for the serial interface engine status, control and address block:
 register offsets, field positions, reset values and carrier structs.
 assumes an apb master with 32-bit data; registers sit in the low byte.
*/
// Summary of operation
// (RULE_01) four-deep status queue read through one window
// (RULE_02) completed descriptor status recorded and appended
// (RULE_03) clearing token done pops one entry
// (RULE_04) token done reasserts at once if more queued
// (RULE_05) endpoint number in upper status bits
// (RULE_06) status bit 3 marks transmit
// (RULE_07) status bit 2 marks odd bank
// (RULE_08) control bit 7 live j state, speed-dependent
// (RULE_09) control bit 6 live single-ended zero
// (RULE_10) host: bit 5 busy while token runs
// (RULE_11) target: setup token sets bit 5, halts
// (RULE_12) host: bit 4 drives bus reset signalling
// (RULE_13) control bit 3 selects host mode
// (RULE_14) control bit 2 drives resume signalling
// (RULE_15) host resume end followed by low-speed eop
// (RULE_16) writing bit 1 forces even banks
// (RULE_17) bit 0 enables module, resets bank selectors
// (RULE_18) host: enable clear stops start-of-frame tokens
// (RULE_19) address bits 6-0 decoded or sent
// (RULE_20) address cleared on reset and bus reset
// (RULE_21) address bit 7 requests low-speed with preamble
// (RULE_22) software keeps enable set for addressing
// (RULE_23) software programs address before token command
// (RULE_24) reserved status bits read zero
`default_nettype none

package sie_ctl_pkg;
   localparam logic [11:0] stat_offset = 12'h000;
   localparam logic [11:0] ctl_offset = 12'h004;
   localparam logic [11:0] addr_offset = 12'h008;
   localparam logic [11:0] int_offset = 12'h00c;

   localparam int ctl_live_j_state_bit = 7;
   localparam int ctl_se0_bit = 6;
   localparam int ctl_busy_bit = 5;
   localparam int ctl_reset_bit = 4;
   localparam int ctl_host_bit = 3;
   localparam int ctl_resume_bit = 2;
   localparam int ctl_odd_rst_bit = 1;
   localparam int ctl_enable_bit = 0;

   localparam int addr_ls_bit = 7;
   localparam int int_token_done_bit = 0;

   localparam logic [7:0] ctl_reset_value = 8'h00;
   localparam logic [7:0] addr_reset_value = 8'h00;
   localparam logic [1:0] stat_reserved = 2'h0;

   localparam int queue_depth = 4;

   // one completed transaction as reported by the engine
   typedef struct packed {
      logic [3:0] endpoint_number_field;
      logic tx;
      logic odd;
   } xact_status_s;

   // line and engine state seen by this block
   typedef struct packed {
      logic live_j_state;
      logic se0;
      logic setup_token_seen;
      logic token_started;
      logic token_finished;
      logic bus_reset_decoded;
   } line_status_s;

   // controls driven to the engine
   typedef struct packed {
      logic host_mode;
      logic drive_bus_reset;
      logic drive_resume;
      logic ls_eop_pulse;
      logic force_even_banks;
      logic module_enable;
      logic sof_enable;
      logic suspend_or_busy_bit;
      logic low_speed_select;
      logic [6:0] device_address;
   } engine_ctl_s;

   function automatic logic [7:0] pack_status(input xact_status_s s);
      return {s.endpoint_number_field, s.tx, s.odd, stat_reserved};
   endfunction
endpackage

`default_nettype wire

// file: hw/sie_status_control.sv
/*
 status queue, control and address registers of a usb serial interface engine.
 assumes the engine reports each finished descriptor by a one-cycle pulse and
 live line levels synchronous to clk_in; software on apb.
*/
// The APB interface to the registers and the placing of the registers were decided locally.
`default_nettype none

module sie_status_control #(
   parameter int depth = sie_ctl_pkg::queue_depth
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic xact_done_in,
   input wire sie_ctl_pkg::xact_status_s xact_status_in,
   input wire sie_ctl_pkg::line_status_s line_in,
   output sie_ctl_pkg::engine_ctl_s engine_out,
   output logic token_done_flag_out,
   output logic queue_overflow_out
);
   localparam int pw = $clog2(depth);

   sie_ctl_pkg::xact_status_s queue [depth];
   logic [pw-1:0] rd_ptr;
   logic [pw-1:0] wr_ptr;
   logic [pw:0] count;
   logic token_done_flag;
   logic [7:0] ctl;
   logic [7:0] addr;
   logic busy;
   logic resume_d;

   logic setup;
   logic wr_acc;
   logic rd_acc;
   logic pop;
   logic push;
   logic wr_ctl;
   logic wr_addr;
   logic wr_int;
   logic known;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction

   assign setup = psel_in && !penable_in;
   assign wr_acc = setup && pwrite_in && pstrb_in[0];
   assign rd_acc = setup && !pwrite_in;
   assign wr_ctl = wr_acc && hit(paddr_in, sie_ctl_pkg::ctl_offset);
   assign wr_addr = wr_acc && hit(paddr_in, sie_ctl_pkg::addr_offset);
   assign wr_int = wr_acc && hit(paddr_in, sie_ctl_pkg::int_offset);
   assign known = hit(paddr_in, sie_ctl_pkg::stat_offset) ||
                  hit(paddr_in, sie_ctl_pkg::ctl_offset) ||
                  hit(paddr_in, sie_ctl_pkg::addr_offset) ||
                  hit(paddr_in, sie_ctl_pkg::int_offset);

   // write-one-to-clear of token done consumes the window entry
   assign pop = wr_int && pwdata_in[sie_ctl_pkg::int_token_done_bit]
                && token_done_flag; // RULE_03
   // a full queue drops the new status and flags overflow unless a pop frees an entry in the same cycle
   assign push = xact_done_in && (count != (pw+1)'(depth) || pop); // RULE_02

   // apb: one-cycle answer, prepared during setup
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= setup;
         pslverr_out <= setup && !known;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (rd_acc) begin
         unique case (1'b1)
            hit(paddr_in, sie_ctl_pkg::stat_offset):
               prdata_out <= {24'h00_0000, count != '0 ?
                  sie_ctl_pkg::pack_status(queue[rd_ptr]) : 8'h00}; // RULE_01 RULE_24
            hit(paddr_in, sie_ctl_pkg::ctl_offset):
               prdata_out <= {24'h00_0000, ctl};
            hit(paddr_in, sie_ctl_pkg::addr_offset):
               prdata_out <= {24'h00_0000, addr};
            hit(paddr_in, sie_ctl_pkg::int_offset):
               prdata_out <= {31'h0000_0000, token_done_flag};
            default:
               prdata_out <= 32'h0000_0000;
         endcase
      end else begin
         prdata_out <= 32'h0000_0000;
      end
   end

   // status queue storage
   always_ff @(posedge clk_in) begin
      if (push) begin
         queue[wr_ptr] <= xact_status_in; // RULE_05 RULE_06 RULE_07
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || !ctl[sie_ctl_pkg::ctl_enable_bit]) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= pw'((wr_ptr + 1'b1) % depth); // RULE_01
         end
         if (pop) begin
            rd_ptr <= pw'((rd_ptr + 1'b1) % depth);
         end
         count <= count + (pw+1)'(push) - (pw+1)'(pop);
      end
   end

   // flag mirrors a non-empty queue: set wins over the clear
   always_ff @(posedge clk_in) begin
      if (rst_in || !ctl[sie_ctl_pkg::ctl_enable_bit]) begin
         token_done_flag <= 1'b0;
      end else begin
         token_done_flag <= push || (count - (pw+1)'(pop)) != '0; // RULE_04
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         queue_overflow_out <= 1'b0;
      end else begin
         queue_overflow_out <= xact_done_in && !push;
      end
   end

   // busy / suspend bit: hardware set; token end clears in host, software clear in target; set wins
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         busy <= 1'b0;
      end else if (ctl[sie_ctl_pkg::ctl_host_bit]) begin
         if (line_in.token_started) begin
            busy <= 1'b1; // RULE_10
         end else if (line_in.token_finished) begin
            busy <= 1'b0;
         end
      end else if (line_in.setup_token_seen) begin
         busy <= 1'b1; // RULE_11
      end else if (wr_ctl && !pwdata_in[sie_ctl_pkg::ctl_busy_bit]) begin
         busy <= 1'b0;
      end
   end

   // control register with live line bits
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctl <= sie_ctl_pkg::ctl_reset_value;
      end else begin
         ctl[sie_ctl_pkg::ctl_live_j_state_bit] <= line_in.live_j_state; // RULE_08
         ctl[sie_ctl_pkg::ctl_se0_bit] <= line_in.se0; // RULE_09
         ctl[sie_ctl_pkg::ctl_busy_bit] <= busy;
         ctl[sie_ctl_pkg::ctl_odd_rst_bit] <= 1'b0;
         if (wr_ctl) begin
            ctl[sie_ctl_pkg::ctl_reset_bit] <= pwdata_in[sie_ctl_pkg::ctl_reset_bit];
            ctl[sie_ctl_pkg::ctl_host_bit] <= pwdata_in[sie_ctl_pkg::ctl_host_bit];
            ctl[sie_ctl_pkg::ctl_resume_bit] <= pwdata_in[sie_ctl_pkg::ctl_resume_bit];
            ctl[sie_ctl_pkg::ctl_enable_bit] <= pwdata_in[sie_ctl_pkg::ctl_enable_bit];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         addr <= sie_ctl_pkg::addr_reset_value;
      end else if (line_in.bus_reset_decoded) begin
         addr <= sie_ctl_pkg::addr_reset_value; // RULE_20
      end else if (wr_addr) begin
         addr <= pwdata_in[7:0]; // RULE_19 RULE_21
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         resume_d <= 1'b0;
      end else begin
         resume_d <= ctl[sie_ctl_pkg::ctl_resume_bit];
      end
   end

   // outputs to the engine, all registered
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         engine_out <= '0;
         token_done_flag_out <= 1'b0;
      end else begin
         token_done_flag_out <= token_done_flag;
         engine_out.host_mode <= ctl[sie_ctl_pkg::ctl_host_bit]; // RULE_13
         engine_out.drive_bus_reset <= ctl[sie_ctl_pkg::ctl_reset_bit]
            && ctl[sie_ctl_pkg::ctl_host_bit]; // RULE_12
         engine_out.drive_resume <= ctl[sie_ctl_pkg::ctl_resume_bit]; // RULE_14
         engine_out.ls_eop_pulse <= resume_d && !ctl[sie_ctl_pkg::ctl_resume_bit]
            && ctl[sie_ctl_pkg::ctl_host_bit]; // RULE_15
         engine_out.force_even_banks <= (wr_ctl &&
            pwdata_in[sie_ctl_pkg::ctl_odd_rst_bit]) || (wr_ctl && // RULE_16
            pwdata_in[sie_ctl_pkg::ctl_enable_bit] &&
            !ctl[sie_ctl_pkg::ctl_enable_bit]); // RULE_17
         engine_out.module_enable <= ctl[sie_ctl_pkg::ctl_enable_bit]; // RULE_17
         engine_out.sof_enable <= ctl[sie_ctl_pkg::ctl_enable_bit]
            && ctl[sie_ctl_pkg::ctl_host_bit]; // RULE_18
         engine_out.suspend_or_busy_bit <= busy;
         engine_out.low_speed_select <= addr[sie_ctl_pkg::addr_ls_bit];
         engine_out.device_address <= addr[6:0];
      end
   end
endmodule // sie_status_control

`default_nettype wire
